/* File: design/chan_xfer_pkg.sv */
// Purpose: Shared constants for the host channel transfer controller.
// Assumes: APB register bus, 32-bit data, registers in the low byte.
// Notes: Byte address of a register is four times its index.
package chan_xfer_pkg;

  // Register indices; byte address is index * 4
  localparam logic [9:0] IDX_CTRL = 10'h1c0; // channel_d_transfer_control
  localparam logic [9:0] IDX_SETUP = 10'h1c1; // channel_d_transfer_setup
  localparam logic [9:0] IDX_MPS_H = 10'h1c2; // Max packet length, high bits
  localparam logic [9:0] IDX_MPS_L = 10'h1c3; // Max packet length, low byte
  localparam logic [9:0] IDX_TOT_HH = 10'h1c4; // Total byte count [31:24]
  localparam logic [9:0] IDX_TOT_HL = 10'h1c5; // Total byte count [23:16]
  localparam logic [9:0] IDX_TOT_LH = 10'h1c6; // Total byte count [15:8]
  localparam logic [9:0] IDX_TOT_LL = 10'h1c7; // Total byte count [7:0]
  localparam logic [9:0] IDX_STAT = 10'h1c8; // channel_event_status
  localparam logic [9:0] IDX_RESULT = 10'h1c9; // channel_result_code

  // Control register fields
  localparam int CTRL_ACK_LSB = 4;
  localparam int CTRL_SPEED_LSB = 2;
  localparam int CTRL_TOGGLE_BIT = 1;
  localparam int CTRL_RUN_BIT = 0;
  // Setup register fields
  localparam int SETUP_TOKEN_LSB = 6;
  localparam int SETUP_KIND_LSB = 4;
  localparam int SETUP_AZL_BIT = 3;
  localparam int SETUP_FREE_BIT = 0;
  localparam logic [7:0] SETUP_WMASK = 8'hf9; // Bits 2-1 reserved
  // Status register fields (write one to clear)
  localparam int STAT_ACK_BIT = 2;
  localparam int STAT_CMP_BIT = 1;
  localparam int STAT_COND_BIT = 0;
  // Result code field position
  localparam int RESULT_LSB = 4;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Token direction codes
  localparam logic [1:0] TOKEN_OUT = 2'b01;
  localparam logic [1:0] TOKEN_IN = 2'b10;
  // Transfer kind codes
  localparam logic [1:0] KIND_BULK = 2'b10;
  localparam logic [1:0] KIND_INTR = 2'b11;
  // Target speed codes
  localparam logic [1:0] SPEED_HS = 2'b00;
  localparam logic [1:0] SPEED_FS = 2'b01;
  localparam logic [1:0] SPEED_LS = 2'b11;

  // Result codes
  localparam logic [2:0] RC_NO_ERROR = 3'h0;
  localparam logic [2:0] RC_STALL = 3'h1;
  localparam logic [2:0] RC_UNDERRUN = 3'h3;
  localparam logic [2:0] RC_RETRY = 3'h4;

  // Outcome codes reported by the packet engine with each transaction
  typedef enum logic [3:0] {
    OC_ACK = 4'h0, OC_NAK = 4'h1, OC_STALL = 4'h2, OC_NYET = 4'h3,
    OC_ERR_HS = 4'h4, OC_TIMEOUT = 4'h5, OC_CRC = 4'h6, OC_STUFF = 4'h7,
    OC_PID_FAIL = 4'h8, OC_PID_BAD = 4'h9
  } outcome_t;

  localparam logic [1:0] NYET_LIMIT = 2'h3; // Consecutive NYETs that trigger a retry

  // Transaction sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } seq_state_t;

endpackage : chan_xfer_pkg

/* File: design/chan_xfer_ctrl.sv */
// Purpose: Transfer control for one host channel: run/stop, toggle, ACK count, results.
// Assumes: Packet engine answers each txn_req with one txn_done pulse and an outcome.
// Notes: APB slave with one wait state; registers live in the low data byte.
//
// Functional notes
// R1: No response or handshake in time: retry error
// R2: CRC or stuffing error in data: retry error
// R3: Bad or undefined PID: retry error
// R4: Interrupt split ERR or three NYETs: retry
// R5: Received toggle mismatch: retry error
// R6: Count ACKs, flag when target reached
// R7: ACK target zero means sixteen
// R8: Speed field selects HS, FS or LS
// R9: Toggle write seeds, read shows live toggle
// R10: Run bit starts, stops, shows activity
// R11: Byte count done: complete flag, run cleared
// R12: Condition change clears run; code tells why
// R13: Stop finishes current transaction, then condition flag; a stop in the txn_done cycle raises no flag of its own
// R14: Stop keeps remaining count and settings
// R15: Software reloads settings for unrelated transfers
// R16: Token field: 01 OUT, 10 IN
// R17: Kind field: 10 bulk, 11 interrupt
// R18: Auto zero-length after exact-multiple OUT transfer
// R19: Unlimited mode ignores total byte count
// R20: Result 000 no error, 001 stall
// R21: Ten-bit max packet length limits packets
// R22: Status flags sticky until software clears
// R23: ACK counter restarts on each start
module chan_xfer_ctrl
  import chan_xfer_pkg::*;
#(
  parameter int MPS_W = 10, // Max packet length width
  parameter int TOT_W = 32  // Total byte count width
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Packet engine side
  output logic txn_req,
  output logic [1:0] txn_token,
  output logic [1:0] txn_kind,
  output logic [1:0] txn_speed,
  output logic txn_toggle,
  output logic [MPS_W:0] txn_len,
  input wire logic txn_done,
  input wire logic [3:0] txn_outcome,
  input wire logic [MPS_W:0] txn_rx_bytes,
  input wire logic txn_rx_toggle,
  input wire logic txn_split
);

  // Smaller of remaining count and packet limit, or the limit in unlimited mode, widened for a full packet
  function automatic logic [MPS_W:0] pkt_len(input logic [TOT_W-1:0] rem,
                                             input logic [MPS_W-1:0] mps,
                                             input logic free);
    logic [MPS_W:0] m;
    m = {1'b0, mps};
    if (free || rem >= TOT_W'(m)) begin
      pkt_len = m;
    end else begin
      pkt_len = rem[MPS_W:0];
    end
  endfunction : pkt_len

  // Register index decode from a byte address
  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    hit = (a[1:0] == 2'b00) && (a[11:2] == idx);
  endfunction : hit

  // Software-visible settings
  logic [3:0] ack_target_q; // ACK count target
  logic [1:0] speed_q; // target_speed_select
  logic toggle_q, toggle_d; // Live data toggle
  logic run_q, run_d; // channel_run as stored
  logic [1:0] token_q; // token_direction
  logic [1:0] kind_q; // transfer_kind
  logic azl_q; // auto_zero_length_enable
  logic free_q; // unlimited_length_enable
  logic [MPS_W-1:0] mps_q; // max_packet_length
  logic [TOT_W-1:0] total_q, total_d; // Remaining byte count
  logic [2:0] stat_q, stat_d; // Sticky event flags
  logic [2:0] result_q, result_d; // result_code_field
  // Sequencer state
  seq_state_t state_q, state_d;
  logic [4:0] ack_cnt_q, ack_cnt_d; // ACKs since start or since the ACK target was last reached
  logic [1:0] nyet_q, nyet_d; // Consecutive NYETs
  logic stop_q, stop_d; // Stop requested mid-transaction
  logic zlp_q, zlp_d; // Zero-length packet owed
  logic zlp_sent_q, zlp_sent_d; // Current packet is the zero-length one
  // Bus outputs
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic txn_req_q;
  logic [MPS_W:0] txn_len_q;

  // APB decode; the access completes on the second access cycle
  wire access = psel && penable;
  wire commit = access && pready_q;
  wire wr = commit && pwrite && pstrb[0];
  wire [7:0] wb = pwdata[7:0];
  wire h_ctrl = hit(paddr, IDX_CTRL);
  wire h_setup = hit(paddr, IDX_SETUP);
  wire h_mps_h = hit(paddr, IDX_MPS_H);
  wire h_mps_l = hit(paddr, IDX_MPS_L);
  wire h_tot_hh = hit(paddr, IDX_TOT_HH);
  wire h_tot_hl = hit(paddr, IDX_TOT_HL);
  wire h_tot_lh = hit(paddr, IDX_TOT_LH);
  wire h_tot_ll = hit(paddr, IDX_TOT_LL);
  wire h_stat = hit(paddr, IDX_STAT);
  wire h_result = hit(paddr, IDX_RESULT);
  wire mapped = h_ctrl | h_setup | h_mps_h | h_mps_l | h_tot_hh | h_tot_hl |
                h_tot_lh | h_tot_ll | h_stat | h_result;
  wire wr_ctrl = wr && h_ctrl;
  wire busy = (state_q == ST_BUSY);
  wire run_rd = run_q | busy; // R10

  // Read mux
  wire [7:0] rd_ctrl = {ack_target_q, speed_q, toggle_q, run_rd}; // R9
  wire [7:0] rd_setup = {token_q, kind_q, azl_q, 2'b00, free_q};
  wire [7:0] rd_mps_h = {{(16 - MPS_W){1'b0}}, mps_q[MPS_W-1:8]};
  wire [7:0] rd_byte =
    h_ctrl ? rd_ctrl :
    h_setup ? rd_setup :
    h_mps_h ? rd_mps_h :
    h_mps_l ? mps_q[7:0] :
    h_tot_hh ? total_q[31:24] :
    h_tot_hl ? total_q[23:16] :
    h_tot_lh ? total_q[15:8] :
    h_tot_ll ? total_q[7:0] :
    h_stat ? {5'b00000, stat_q} :
    h_result ? {1'b0, result_q, 4'h0} : 8'h00;

  // Outcome decode of a finished transaction
  wire is_out = (token_q == TOKEN_OUT); // R16
  wire is_intr = (kind_q == KIND_INTR); // R17
  outcome_t oc;
  assign oc = outcome_t'(txn_outcome);
  wire oc_hard = (oc == OC_TIMEOUT) || (oc == OC_CRC) || (oc == OC_STUFF) || // R1 R2
                 (oc == OC_PID_FAIL) || (oc == OC_PID_BAD); // R3
  wire split_int = txn_split && is_intr;
  wire err_hs = split_int && (oc == OC_ERR_HS); // R4
  wire nyet_3 = split_int && (oc == OC_NYET) && (nyet_q == NYET_LIMIT - 2'h1); // R4
  wire tog_bad = !is_out && (oc == OC_ACK) && (txn_rx_toggle != toggle_q); // R5
  wire retry = oc_hard || err_hs || nyet_3 || tog_bad;
  wire good = (oc == OC_ACK) && !tog_bad;
  wire stall = (oc == OC_STALL);
  // Bytes moved by a good transaction
  wire [MPS_W:0] moved = is_out ? txn_len_q : txn_rx_bytes;
  wire [TOT_W-1:0] moved_w = TOT_W'(moved);
  wire [TOT_W-1:0] rem_next = (moved_w >= total_q) ? '0 : total_q - moved_w;
  wire full_pkt = (moved == {1'b0, mps_q}); // R21
  wire short_in = !is_out && !full_pkt && (rem_next != '0);
  // ACK target with zero standing for sixteen
  wire [4:0] ack_goal = (ack_target_q == 4'h0) ? 5'h10 : {1'b0, ack_target_q}; // R7
  wire [4:0] ack_inc = ack_cnt_q + 5'h01;

  // Sequencer and event logic
  always_comb begin
    state_d = state_q;
    run_d = run_q;
    toggle_d = toggle_q;
    total_d = total_q;
    stat_d = stat_q;
    result_d = result_q;
    ack_cnt_d = ack_cnt_q;
    nyet_d = nyet_q;
    stop_d = stop_q;
    zlp_d = zlp_q;
    zlp_sent_d = zlp_sent_q;
    // Software writes to the sticky flags clear them first; events below win
    if (wr && h_stat) begin
      stat_d = stat_q & ~wb[2:0]; // R22
    end
    // Software writes to the control register
    if (wr_ctrl) begin
      if (!busy) begin
        toggle_d = wb[CTRL_TOGGLE_BIT]; // R9
      end
      if (wb[CTRL_RUN_BIT] && !run_q && !busy) begin
        run_d = 1'b1; // R10
        ack_cnt_d = 5'h00; // R23
        nyet_d = 2'h0;
      end else if (!wb[CTRL_RUN_BIT] && run_q) begin
        run_d = 1'b0; // R10
        if (busy) begin
          stop_d = 1'b1; // R13
        end else begin
          stat_d[STAT_COND_BIT] = 1'b1; // R13
        end
      end
    end
    case (state_q)
      ST_IDLE: begin
        // Issue only while running; settings and remaining count are kept on stop
        if (run_q && !stop_q) begin // R14
          state_d = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (txn_done) begin
          state_d = ST_IDLE;
          stop_d = 1'b0;
          nyet_d = (oc == OC_NYET) ? nyet_q + 2'h1 : 2'h0;
          if (retry) begin
            result_d = RC_RETRY; // R1 R2 R3 R4 R5
            stat_d[STAT_COND_BIT] = 1'b1; // R12
            run_d = 1'b0; // R12
            nyet_d = 2'h0;
          end else if (stall) begin
            result_d = RC_STALL; // R20
            stat_d[STAT_COND_BIT] = 1'b1; // R12
            run_d = 1'b0; // R12
          end else if (good) begin
            toggle_d = ~toggle_q; // R9
            ack_cnt_d = ack_inc; // R6
            if (ack_inc == ack_goal) begin
              stat_d[STAT_ACK_BIT] = 1'b1; // R6
              ack_cnt_d = 5'h00;
            end
            if (!free_q) begin // R19
              total_d = rem_next;
            end
            zlp_sent_d = 1'b0;
            if (free_q) begin
              // Unlimited: never completes on count
            end else if (zlp_sent_q) begin
              result_d = RC_NO_ERROR; // R20
              stat_d[STAT_CMP_BIT] = 1'b1; // R11
              run_d = 1'b0; // R11
            end else if (short_in) begin
              result_d = RC_UNDERRUN;
              stat_d[STAT_COND_BIT] = 1'b1; // R12
              run_d = 1'b0; // R12
            end else if (rem_next == '0) begin
              if (is_out && azl_q && full_pkt) begin
                zlp_d = 1'b1; // R18
              end else begin
                result_d = RC_NO_ERROR; // R20
                stat_d[STAT_CMP_BIT] = 1'b1; // R11
                run_d = 1'b0; // R11
              end
            end
          end
          // A stop that waited for this transaction reports now
          if (stop_q && run_d) begin
            run_d = 1'b0;
          end
          if (stop_q) begin
            stat_d[STAT_COND_BIT] = 1'b1; // R13
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Owed zero-length packet becomes the current one when a transaction is launched
    if (state_q == ST_IDLE && state_d == ST_BUSY && zlp_q) begin
      zlp_d = 1'b0;
      zlp_sent_d = 1'b1; // R18
    end
  end

  // Launch length: zero for the owed empty packet, else bounded by max packet
  wire launch = (state_q == ST_IDLE) && (state_d == ST_BUSY);
  wire [MPS_W:0] len_new = zlp_q ? '0 : pkt_len(total_q, mps_q, free_q); // R21

  // Settings registers written by software
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_target_q <= REG_RESET[7:4];
      speed_q <= REG_RESET[3:2];
      token_q <= REG_RESET[7:6];
      kind_q <= REG_RESET[5:4];
      azl_q <= 1'b0;
      free_q <= 1'b0;
      mps_q <= '0;
    end else if (wr && !busy) begin
      // Settings are frozen while a transaction is on the wire
      if (h_ctrl) begin
        ack_target_q <= wb[CTRL_ACK_LSB +: 4]; // R7
        speed_q <= wb[CTRL_SPEED_LSB +: 2]; // R8
      end
      if (h_setup) begin
        token_q <= wb[SETUP_TOKEN_LSB +: 2]; // R16
        kind_q <= wb[SETUP_KIND_LSB +: 2]; // R17
        azl_q <= wb[SETUP_AZL_BIT] & SETUP_WMASK[SETUP_AZL_BIT];
        free_q <= wb[SETUP_FREE_BIT] & SETUP_WMASK[SETUP_FREE_BIT]; // R19
      end
      if (h_mps_h) begin
        mps_q[MPS_W-1:8] <= wb[MPS_W-9:0];
      end
      if (h_mps_l) begin
        mps_q[7:0] <= wb;
      end
    end
  end

  // Remaining count: software loads bytes while idle, sequencer counts down
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      total_q <= '0;
    end else if (wr && !busy && h_tot_hh) begin
      total_q[31:24] <= wb;
    end else if (wr && !busy && h_tot_hl) begin
      total_q[23:16] <= wb;
    end else if (wr && !busy && h_tot_lh) begin
      total_q[15:8] <= wb;
    end else if (wr && !busy && h_tot_ll) begin
      total_q[7:0] <= wb;
    end else begin
      total_q <= total_d; // R14
    end
  end

  // Sequencer state and flags
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      run_q <= 1'b0;
      toggle_q <= 1'b0;
      stat_q <= 3'h0;
      result_q <= RC_NO_ERROR;
      ack_cnt_q <= 5'h00;
      nyet_q <= 2'h0;
      stop_q <= 1'b0;
      zlp_q <= 1'b0;
      zlp_sent_q <= 1'b0;
    end else begin
      state_q <= state_d;
      run_q <= run_d;
      toggle_q <= toggle_d;
      stat_q <= stat_d;
      result_q <= result_d;
      ack_cnt_q <= ack_cnt_d;
      nyet_q <= nyet_d;
      stop_q <= stop_d;
      zlp_q <= zlp_d;
      zlp_sent_q <= zlp_sent_d;
    end
  end

  // Request to the packet engine, held until its done pulse
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      txn_req_q <= 1'b0;
      txn_len_q <= '0;
    end else begin
      txn_req_q <= (state_d == ST_BUSY) && !(busy && txn_done);
      if (launch) begin
        txn_len_q <= len_new;
      end
    end
  end

  // APB answer: one wait state, error on unmapped address
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= access && !pready_q;
      pslverr_q <= access && !pready_q && !mapped;
      if (access && !pready_q) begin
        prdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign txn_req = txn_req_q;
  assign txn_token = token_q;
  assign txn_kind = kind_q;
  assign txn_speed = speed_q; // R8
  assign txn_toggle = toggle_q;
  assign txn_len = txn_len_q;

endmodule : chan_xfer_ctrl

/* File: sim/chan_xfer_ctrl_checker.sv */
// Purpose: Port assertions for the channel transfer controller.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every controller instance.
module chan_xfer_ctrl_checker
  import chan_xfer_pkg::*;
#(
  parameter int MPS_W = 10,
  parameter int TOT_W = 32
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic txn_req,
  input wire logic [1:0] txn_token,
  input wire logic txn_toggle,
  input wire logic [MPS_W:0] txn_len,
  input wire logic txn_done,
  input wire logic [3:0] txn_outcome
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // Address outside the register block
  wire unmapped = paddr[11:2] < IDX_CTRL || paddr[11:2] > IDX_RESULT;
  // Committed write of a one to the run bit
  wire run_wr = psel && penable && pready && pwrite && pstrb[0]
    && paddr[11:2] == IDX_CTRL && pwdata[0];
  // Replies that always end the transfer
  wire fatal = txn_req && txn_done && txn_outcome inside
    {OC_TIMEOUT, OC_CRC, OC_STUFF, OC_PID_FAIL, OC_PID_BAD, OC_STALL};
  wire out_ack = txn_req && txn_done && txn_outcome == OC_ACK && txn_token == TOKEN_OUT;

  a_pready_slot: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (pready |-> pslverr == unmapped)
    else $error("pslverr does not match address map");
  a_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_run_starts: assert property (run_wr && !txn_req |=> ##[0:2] txn_req)
    else $error("run write did not start a transaction");
  a_req_holds: assert property (txn_req && !txn_done |=> txn_req && $stable(txn_len))
    else $error("request changed before done");
  a_req_drops: assert property (txn_req && txn_done |=> !txn_req)
    else $error("request did not drop after done");
  a_fatal_halt: assert property (fatal |=> !txn_req [*4])
    else $error("transfer went on after a fatal reply");
  a_toggle_flip: assert property (out_ack |=> txn_toggle != $past(txn_toggle))
    else $error("toggle did not advance after ACK");
endmodule : chan_xfer_ctrl_checker

bind chan_xfer_ctrl chan_xfer_ctrl_checker #(.MPS_W(MPS_W), .TOT_W(TOT_W)) i_chan_xfer_ctrl_checker (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .txn_req(txn_req), .txn_token(txn_token), .txn_toggle(txn_toggle),
  .txn_len(txn_len), .txn_done(txn_done), .txn_outcome(txn_outcome));

/* File: sim/usb_func_model.sv */
// Purpose: Behavioural packet engine with the attached function.
// Assumes: One request at a time, answered after cfg_delay cycles.
// Notes: Reply fields flip while idle so stale data never looks valid.
module usb_func_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic txn_req,
  input wire logic txn_toggle,
  input wire logic [10:0] txn_len,
  input wire logic [3:0] cfg_outcome,
  input wire logic [7:0] cfg_delay,
  input wire logic cfg_bad_toggle,
  input wire logic cfg_split,
  output logic txn_done,
  output logic [3:0] txn_outcome,
  output logic [10:0] txn_rx_bytes,
  output logic txn_rx_toggle,
  output logic txn_split,
  output logic [7:0] txn_count,
  output logic [10:0] last_len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wait_q; // Cycles spent on this request
  // Answer each request once, then let it drop
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      txn_done <= 1'b0;
      wait_q <= 8'h00;
      txn_count <= 8'h00;
      last_len <= 11'h000;
      txn_outcome <= 4'h0;
      txn_rx_bytes <= 11'h000;
      txn_rx_toggle <= 1'b0;
      txn_split <= 1'b0;
    end else if (txn_done) begin
      txn_done <= 1'b0;
      wait_q <= 8'h00;
    end else if (txn_req && wait_q >= cfg_delay) begin
      txn_done <= 1'b1;
      txn_outcome <= cfg_outcome;
      txn_rx_bytes <= 11'h008;
      txn_rx_toggle <= txn_toggle ^ cfg_bad_toggle; // Wrong toggle only on command
      txn_split <= cfg_split;
      txn_count <= txn_count + 8'h01;
      last_len <= txn_len;
    end else begin
      wait_q <= txn_req ? wait_q + 8'h01 : 8'h00;
      txn_outcome <= ~txn_outcome;
      txn_rx_bytes <= ~txn_rx_bytes;
      txn_rx_toggle <= ~txn_rx_toggle;
      txn_split <= ~txn_split;
    end
  end
endmodule : usb_func_model

/* File: sim/chan_xfer_ctrl_tb.sv */
// Purpose: Self-checking bench for the channel transfer controller.
// Assumes: APB answer arrives with pready, after any number of wait states.
// Notes: Packet engine side is a behavioural model.
module chan_xfer_ctrl_tb;
  import chan_xfer_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr, txn_req, txn_toggle, txn_done, txn_rx_toggle, txn_split;
  logic [1:0] txn_token, txn_kind, txn_speed;
  logic [10:0] txn_len, txn_rx_bytes, last_len;
  logic [3:0] txn_outcome;
  logic [3:0] cfg_outcome = 4'h0; // Reply the model gives
  logic [7:0] cfg_delay = 8'h03; // Model answer latency
  logic cfg_bad_toggle = 1'b0;
  logic cfg_split = 1'b0;
  logic [7:0] txn_count, base; // Base taken at each start
  logic [7:0] rd; // Last read byte
  logic err; // Last error response
  int fail_count = 0;
  int checked = 0;
  // Error replies; the last one is a good ACK with a wrong toggle
  logic [3:0] oc [9] = '{OC_TIMEOUT, OC_CRC, OC_STUFF, OC_PID_FAIL, OC_PID_BAD,
    OC_ERR_HS, OC_NYET, OC_STALL, OC_ACK};
  logic [1:0] spd [3] = '{SPEED_HS, SPEED_FS, SPEED_LS};

  always #25 clk_sys = ~clk_sys;

  chan_xfer_ctrl i_chan_xfer_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .txn_req(txn_req),
    .txn_token(txn_token), .txn_kind(txn_kind), .txn_speed(txn_speed),
    .txn_toggle(txn_toggle), .txn_len(txn_len), .txn_done(txn_done),
    .txn_outcome(txn_outcome), .txn_rx_bytes(txn_rx_bytes),
    .txn_rx_toggle(txn_rx_toggle), .txn_split(txn_split));
  usb_func_model i_usb_func_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .txn_req(txn_req),
    .txn_toggle(txn_toggle), .txn_len(txn_len), .cfg_outcome(cfg_outcome),
    .cfg_delay(cfg_delay), .cfg_bad_toggle(cfg_bad_toggle), .cfg_split(cfg_split),
    .txn_done(txn_done), .txn_outcome(txn_outcome), .txn_rx_bytes(txn_rx_bytes),
    .txn_rx_toggle(txn_rx_toggle), .txn_split(txn_split), .txn_count(txn_count),
    .last_len(last_len));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; request held until pready is sampled
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    // No fixed wait state count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle keeps psel from being driven twice in one step
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr

  task automatic rdchk(input string what, input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(what, {24'h000000, rd}, {24'h000000, exp});
  endtask : rdchk

  // Fresh transfer: status cleared, all settings rewritten, then run
  task automatic start(input logic [7:0] setup, input logic [7:0] total, input logic [7:0] ctrl);
    wr(IDX_STAT, 8'h07);
    wr(IDX_SETUP, setup);
    wr(IDX_MPS_H, 8'h00);
    wr(IDX_MPS_L, 8'h08);
    for (int i = 0; i < 3; i++) wr(IDX_TOT_HH + 10'(i), 8'h00);
    wr(IDX_TOT_LL, total);
    base = txn_count;
    wr(IDX_CTRL, ctrl);
  endtask : start

  // Poll the run bit until the channel is idle
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, IDX_CTRL, 8'h00);
      n++;
    end while (rd[0] !== 1'b0 && n < 200);
    check("idle", {31'h0, rd[0]}, 32'h0);
  endtask : wait_idle

  task automatic wait_cnt(input logic [7:0] n);
    while (txn_count - base !== n) begin
      @(posedge clk_sys);
    end
  endtask : wait_cnt

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // Watchdog: the tests need well under this many cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rdchk("ctrl", IDX_CTRL, REG_RESET);
    rdchk("setup", IDX_SETUP, REG_RESET);
    apb(1'b0, 10'h1cf, 8'h00);
    check("slverr", {31'h0, err}, 32'h1);
    check("unmapped", {24'h000000, rd}, 32'h0);
    $display("Test reset done");
    // Bulk OUT of two full packets, ACK target two
    start(8'h60, 8'h10, 8'h25);
    wait_idle();
    rdchk("status", IDX_STAT, 8'h06);
    rdchk("ctrl", IDX_CTRL, 8'h24);
    rdchk("result", IDX_RESULT, 8'h00);
    check("count", 32'(txn_count - base), 32'h2);
    check("len", 32'(last_len), 32'h8);
    check("kind", 32'(txn_kind), 32'(KIND_BULK));
    rdchk("status", IDX_STAT, 8'h06);
    wr(IDX_STAT, 8'h07);
    rdchk("status", IDX_STAT, 8'h00);
    $display("Test bulk done");
    // Error replies stop the transfer with a result code
    cfg_split <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      cfg_outcome <= oc[i];
      cfg_bad_toggle <= (i == 8);
      start(i == 8 ? 8'hb0 : 8'h70, 8'h10, {4'h1, spd[i % 3], 2'b01});
      wait_idle();
      rdchk("status", IDX_STAT, 8'h01);
      rdchk("result", IDX_RESULT, {1'b0, i == 7 ? RC_STALL : RC_RETRY, 4'h0});
      check("count", 32'(txn_count - base), i == 6 ? 32'h3 : 32'h1);
      check("speed", 32'(txn_speed), 32'(spd[i % 3]));
      check("token", 32'(txn_token), i == 8 ? 32'(TOKEN_IN) : 32'(TOKEN_OUT));
      check("kind", 32'(txn_kind), 32'(KIND_INTR));
    end
    cfg_split <= 1'b0;
    cfg_outcome <= OC_ACK;
    cfg_bad_toggle <= 1'b0;
    $display("Test errors done");
    // Exact multiple OUT with auto zero-length
    start(8'h68, 8'h08, 8'h01);
    wait_idle();
    check("count", 32'(txn_count - base), 32'h2);
    check("len", 32'(last_len), 32'h0);
    rdchk("status", IDX_STAT, 8'h02);
    $display("Test zero length done");
    // Stop in flight, then resume the remainder
    cfg_delay <= 8'h14;
    start(8'h60, 8'h18, 8'h31);
    wr(IDX_CTRL, 8'h30);
    wait_idle();
    check("count", 32'(txn_count - base), 32'h1);
    rdchk("status", IDX_STAT, 8'h01);
    rdchk("ctrl", IDX_CTRL, 8'h32);
    wr(IDX_CTRL, 8'h33);
    wait_idle();
    check("count", 32'(txn_count - base), 32'h3);
    rdchk("status", IDX_STAT, 8'h03);
    rdchk("ctrl", IDX_CTRL, 8'h32);
    $display("Test stop resume done");
    // Unlimited length, ACK target zero means sixteen
    start(8'h61, 8'h08, 8'h01);
    wait_cnt(8'h0f);
    rdchk("status", IDX_STAT, 8'h00);
    wait_cnt(8'h10);
    repeat (2) @(posedge clk_sys);
    rdchk("status", IDX_STAT, 8'h04);
    rdchk("ctrl", IDX_CTRL, 8'h01);
    wr(IDX_CTRL, 8'h00);
    wait_idle();
    $display("Test unlimited done");
    complete_run();
  end
endmodule : chan_xfer_ctrl_tb
